// ---- hdl/vphyc_basic_control.sv ----
`timescale 1ns/10ps
// Behaviour
// - Writing one to bit 15 restores all emulated registers; bit clears itself.
// - Bit 14 loops MAC transmit frames back to its receive path.
// - Bit 13 picks 10 or 100/200 Mbps when negotiation is off; resets zero.
// - Bit 12 enables negotiation, resets one, overrides manual speed and duplex.
// - MAC modes with negotiation on take duplex, and RMII speed, from pins.
// - Bits 11 and 7 are stored, read back, default zero, do nothing.
// - Bit 6 is read only and always reads zero.
// - Bit 10 in RMII PHY mode tristates outputs, drops pulls, powers inputs down.
// - In MAC modes the isolate bit has no effect on pins.
// - Isolation never touches the management data pin.
// - Writing one to bit 9 reruns emulated negotiation; bit clears itself.
// - Bit 8 picks half or full duplex when negotiation is off; resets zero.
// - Register is 32 bits in memory map, 16 bits at serial index 0.
// - MAC mode negotiation: full duplex when duplex pin equals its strap.
// - RMII MAC negotiation: 100 Mbps when speed pin equals its strap.
module vphyc_basic_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Memory mapped access
  input wire logic [11:0] i_mm_addr,
  input wire logic i_mm_wr_en,
  input wire logic i_mm_rd_en,
  input wire logic [31:0] i_mm_wdata,
  output logic [31:0] o_mm_rdata,
  output logic o_mm_rd_valid,
  // Serial management access, already decoded for this PHY address
  input wire logic [4:0] i_smi_index,
  input wire logic i_smi_wr_en,
  input wire logic i_smi_rd_en,
  input wire logic [15:0] i_smi_wdata,
  output logic [15:0] o_smi_rdata,
  output logic o_smi_rd_valid,
  // Mode and straps, from configuration logic on this clock
  input wire logic [1:0] i_mode,
  input wire logic i_duplex_pol_strap,
  input wire logic i_speed_pol_strap,
  // External PHY indication pins
  input wire logic i_port_zero_duplex_input,
  input wire logic i_port_zero_speed_input,
  // Fabric and pin control
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_loop_enable,
  output logic o_rmii_out_disable,
  output logic o_rmii_pull_disable,
  output logic o_rmii_in_power_down,
  output logic o_soft_reset_pulse,
  output logic o_autoneg_restart_pulse
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic duplex_pin;
  logic speed_pin;

  vphyc_pin_sync u_duplex_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_port_zero_duplex_input),
    .o_level(duplex_pin)
  );

  vphyc_pin_sync u_speed_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_port_zero_speed_input),
    .o_level(speed_pin)
  );

  // ****************************************************************
  // Control register and access decode
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic an_speed_q;
  logic an_speed_d;
  logic an_duplex_q;
  logic an_duplex_d;
  logic mm_hit;
  logic smi_hit;
  logic wr_hit;
  logic [15:0] wr_data;
  logic [15:0] read_view;

  assign mm_hit = (i_mm_addr == vphyc_pkg::CTRL_OFFSET);
  assign smi_hit = (i_smi_index == vphyc_pkg::CTRL_INDEX);
  assign wr_hit = (i_mm_wr_en && mm_hit) || (i_smi_wr_en && smi_hit);
  // Memory map wins when both ports write together; upper 16 bits are dropped.
  assign wr_data = (i_mm_wr_en && mm_hit) ? i_mm_wdata[15:0] : i_smi_wdata;

  assign read_view = ctrl_q & 16'hFF80;

  // Next value of the control word and the emulated negotiation result.
  always_comb begin
    ctrl_d = ctrl_q;
    an_speed_d = an_speed_q;
    an_duplex_d = an_duplex_q;
    // Action bits live for exactly one cycle after the write that set them.
    ctrl_d[vphyc_pkg::BIT_AUTONEG_RESTART] = 1'b0;
    ctrl_d[vphyc_pkg::BIT_SOFT_RESET] = 1'b0;
    if (ctrl_q[vphyc_pkg::BIT_SOFT_RESET]) begin
      ctrl_d = vphyc_pkg::CTRL_RESET_VALUE;
      an_speed_d = vphyc_pkg::AN_RESULT_SPEED_RESET;
      an_duplex_d = vphyc_pkg::AN_RESULT_DUPLEX_RESET;
    end else if (wr_hit) begin
      ctrl_d = wr_data & (vphyc_pkg::CTRL_STORE_MASK |
                          16'h8000 | 16'h0200);
    end
    if (ctrl_q[vphyc_pkg::BIT_AUTONEG_RESTART] && !ctrl_q[vphyc_pkg::BIT_SOFT_RESET]) begin
      an_speed_d = vphyc_pkg::AN_RESULT_SPEED_RESET;
      an_duplex_d = vphyc_pkg::AN_RESULT_DUPLEX_RESET;
    end
  end

  // Control word registers.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= vphyc_pkg::CTRL_RESET_VALUE;
      an_speed_q <= vphyc_pkg::AN_RESULT_SPEED_RESET;
      an_duplex_q <= vphyc_pkg::AN_RESULT_DUPLEX_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      an_speed_q <= an_speed_d;
      an_duplex_q <= an_duplex_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] mm_rdata_q;
  logic [31:0] mm_rdata_d;
  logic mm_rd_valid_q;
  logic mm_rd_valid_d;
  logic [15:0] smi_rdata_q;
  logic [15:0] smi_rdata_d;
  logic smi_rd_valid_q;
  logic smi_rd_valid_d;

  // 32 bit view with upper half zero, 16 bit serial view.
  always_comb begin
    mm_rdata_d = mm_rdata_q;
    smi_rdata_d = smi_rdata_q;
    mm_rd_valid_d = i_mm_rd_en;
    smi_rd_valid_d = i_smi_rd_en;
    if (i_mm_rd_en) begin
      // Other emulated registers sit elsewhere, so a miss reads zero.
      mm_rdata_d = mm_hit ? {16'h0000, read_view} : 32'h0000_0000;
    end
    if (i_smi_rd_en) begin
      smi_rdata_d = smi_hit ? read_view : 16'h0000;
    end
  end

  // Read data registers.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mm_rdata_q <= 32'h0000_0000;
      mm_rd_valid_q <= 1'b0;
      smi_rdata_q <= 16'h0000;
      smi_rd_valid_q <= 1'b0;
    end else begin
      mm_rdata_q <= mm_rdata_d;
      mm_rd_valid_q <= mm_rd_valid_d;
      smi_rdata_q <= smi_rdata_d;
      smi_rd_valid_q <= smi_rd_valid_d;
    end
  end

  // ****************************************************************
  // Speed, duplex, loopback and isolation
  // ****************************************************************
  logic mac_mode;
  logic an_on;
  logic speed_d;
  logic speed_q;
  logic duplex_d;
  logic duplex_q;
  logic loop_q;
  logic iso_d;
  logic iso_q;
  logic soft_pulse_q;
  logic restart_pulse_q;

  assign mac_mode = (i_mode == vphyc_pkg::MODE_MII_MAC) ||
                    (i_mode == vphyc_pkg::MODE_RMII_MAC);
  assign an_on = ctrl_q[vphyc_pkg::BIT_AUTONEG_ENABLE];

  // Fabric speed and duplex selection.
  always_comb begin
    speed_d = ctrl_q[vphyc_pkg::BIT_SPEED_SELECT];
    duplex_d = ctrl_q[vphyc_pkg::BIT_DUPLEX_SELECT];
    if (an_on) begin
      speed_d = an_speed_q;
      duplex_d = an_duplex_q;
      if (mac_mode) begin
        duplex_d = (duplex_pin == i_duplex_pol_strap);
      end
      if (i_mode == vphyc_pkg::MODE_RMII_MAC) begin
        speed_d = (speed_pin == i_speed_pol_strap);
      end
    end
    iso_d = ctrl_q[vphyc_pkg::BIT_ISOLATE] && (i_mode == vphyc_pkg::MODE_RMII_PHY);
  end

  // Output registers; the management data pin is not controlled here at all.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      speed_q <= vphyc_pkg::AN_RESULT_SPEED_RESET;
      duplex_q <= vphyc_pkg::AN_RESULT_DUPLEX_RESET;
      loop_q <= 1'b0;
      iso_q <= 1'b0;
      soft_pulse_q <= 1'b0;
      restart_pulse_q <= 1'b0;
    end else begin
      speed_q <= speed_d;
      duplex_q <= duplex_d;
      loop_q <= ctrl_q[vphyc_pkg::BIT_LOOP_ENABLE];
      iso_q <= iso_d;
      soft_pulse_q <= ctrl_q[vphyc_pkg::BIT_SOFT_RESET];
      restart_pulse_q <= ctrl_q[vphyc_pkg::BIT_AUTONEG_RESTART];
    end
  end

  assign o_mm_rdata = mm_rdata_q;
  assign o_mm_rd_valid = mm_rd_valid_q;
  assign o_smi_rdata = smi_rdata_q;
  assign o_smi_rd_valid = smi_rd_valid_q;
  assign o_speed_100 = speed_q;
  assign o_full_duplex = duplex_q;
  assign o_loop_enable = loop_q;
  assign o_rmii_out_disable = iso_q;
  assign o_rmii_pull_disable = iso_q;
  assign o_rmii_in_power_down = iso_q;
  assign o_soft_reset_pulse = soft_pulse_q;
  assign o_autoneg_restart_pulse = restart_pulse_q;

endmodule

// ---- hdl/vphyc_pin_sync.sv ----
`timescale 1ns/10ps
// Three stage pin synchroniser; a change is accepted once stages one and two agree.
module vphyc_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pin and result
  input wire logic i_pin,
  output logic o_level
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_q;
  logic level_d;

  // Shift chain; stage zero feeds only stage one to keep metastability contained.
  always_comb begin
    stage_d = {stage_q[1:0], i_pin};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  // Register stage.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule

// ---- hdl/vphyc_pkg.sv ----
package vphyc_pkg;

  // ****************************************************************
  // Register placement
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET = 12'h1C0;
  localparam logic [4:0] CTRL_INDEX = 5'h00;

  // ****************************************************************
  // Field positions inside the control word
  // ****************************************************************
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOP_ENABLE = 14;
  localparam int BIT_SPEED_SELECT = 13;
  localparam int BIT_AUTONEG_ENABLE = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AUTONEG_RESTART = 9;
  localparam int BIT_DUPLEX_SELECT = 8;
  localparam int BIT_COLLISION_TEST = 7;

  // Bits software may store; bits 15 and 9 are self clearing actions.
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7D80;
  localparam logic [15:0] CTRL_RESET_VALUE = 16'h1000;

  // ****************************************************************
  // Device operating modes
  // ****************************************************************
  localparam logic [1:0] MODE_MII_PHY = 2'h0;
  localparam logic [1:0] MODE_RMII_PHY = 2'h1;
  localparam logic [1:0] MODE_MII_MAC = 2'h2;
  localparam logic [1:0] MODE_RMII_MAC = 2'h3;

  // ****************************************************************
  // Emulated negotiation result and pin synchroniser depth
  // ****************************************************************
  localparam logic AN_RESULT_SPEED_RESET = 1'b1;
  localparam logic AN_RESULT_DUPLEX_RESET = 1'b1;
  localparam int SYNC_STAGES = 3;

endpackage

// ---- tb/tb_virtual_phy_basic_control.sv ----
`timescale 1ns/10ps
module tb_virtual_phy_basic_control;
  logic i_clk = 1'h0, i_sys_rst = 1'h1, i_mm_wr_en = 1'h0, i_mm_rd_en = 1'h0;
  logic i_smi_wr_en = 1'h0, i_smi_rd_en = 1'h0, i_duplex_pol_strap = 1'h0;
  logic i_speed_pol_strap = 1'h0, full = 1'h0, fast = 1'h0;
  logic [11:0] i_mm_addr = 12'h000;
  logic [31:0] i_mm_wdata = 32'h0, o_mm_rdata;
  logic [4:0] i_smi_index = 5'h00;
  logic [15:0] i_smi_wdata = 16'h0, o_smi_rdata;
  logic [1:0] i_mode = 2'h0;
  logic o_mm_rd_valid, o_smi_rd_valid, i_port_zero_duplex_input, i_port_zero_speed_input;
  logic o_speed_100, o_full_duplex, o_loop_enable, o_rmii_out_disable, o_rmii_pull_disable;
  logic o_rmii_in_power_down, o_soft_reset_pulse, o_autoneg_restart_pulse;
  int n_fail = 0;
  int num_checks = 0;
  // ****
  // Clock, design and far side
  // ****
  always #5 i_clk = ~i_clk;
  vphyc_basic_control DUT (.i_clk, .i_sys_rst, .i_mm_addr, .i_mm_wr_en, .i_mm_rd_en,
    .i_mm_wdata, .o_mm_rdata, .o_mm_rd_valid, .i_smi_index, .i_smi_wr_en, .i_smi_rd_en,
    .i_smi_wdata, .o_smi_rdata, .o_smi_rd_valid, .i_mode, .i_duplex_pol_strap,
    .i_speed_pol_strap, .i_port_zero_duplex_input, .i_port_zero_speed_input, .o_speed_100,
    .o_full_duplex, .o_loop_enable, .o_rmii_out_disable, .o_rmii_pull_disable,
    .o_rmii_in_power_down, .o_soft_reset_pulse, .o_autoneg_restart_pulse);
  vphyc_far_model far (.i_clk, .i_full(full), .i_fast(fast),
    .o_duplex(i_port_zero_duplex_input), .o_speed(i_port_zero_speed_input));
  // ****
  // Shared tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Wide enough to carry a valid bit above a full 32 bit read word.
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Strobes drop one edge later; mm_rd and smi then idle a cycle, mm_wr returns at once.
  task automatic mm_wr(input logic [11:0] a, input logic [31:0] d);
    i_mm_addr = a;
    i_mm_wdata = d;
    i_mm_wr_en = 1'h1;
    tick(1);
    i_mm_wr_en = 1'h0;
  endtask
  task automatic mm_rd(input logic [11:0] a, input logic [31:0] e);
    i_mm_addr = a;
    i_mm_rd_en = 1'h1;
    tick(1);
    i_mm_rd_en = 1'h0;
    chk({o_mm_rd_valid, o_mm_rdata}, {1'h1, e});
    tick(1);
  endtask
  task automatic smi(input logic w, input logic [4:0] i, input logic [15:0] d);
    i_smi_index = i;
    i_smi_wdata = d;
    i_smi_wr_en = w;
    i_smi_rd_en = !w;
    tick(1);
    i_smi_wr_en = 1'h0;
    i_smi_rd_en = 1'h0;
    if (!w) chk({o_smi_rd_valid, o_smi_rdata}, {1'h1, d});
    tick(1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_fields;
    mm_rd(12'h1C0, 32'h1000);
    chk({o_speed_100, o_full_duplex, o_loop_enable}, 32'h6);
    mm_wr(12'h1C0, 32'hFFFF_7FFF);
    tick(1);
    chk({o_loop_enable, o_autoneg_restart_pulse}, 32'h3);
    mm_rd(12'h1C0, 32'h7D80);
    // Bit six was written as one just before and must still read zero.
    mm_rd(12'h1C0, 32'h7D80);
    mm_wr(12'h1C4, 32'h0);
    mm_rd(12'h1C4, 32'h0);
    smi(1'h0, 5'h00, 16'h7D80);
    $display("fields done");
  endtask
  task automatic t_manual;
    mm_wr(12'h1C0, 32'h2000);
    tick(1);
    chk({o_speed_100, o_full_duplex}, 32'h2);
    smi(1'h1, 5'h00, 16'h0100);
    chk({o_speed_100, o_full_duplex}, 32'h1);
    i_mode = 2'h3;
    tick(10);
    chk({o_speed_100, o_full_duplex}, 32'h1);
    $display("manual done");
  endtask
  task automatic t_mac;
    logic [3:0] k;
    mm_wr(12'h1C0, 32'h1000);
    for (k = 4'h0; k < 4'h8; k++) begin
      i_mode = k[2] ? 2'h3 : 2'h2;
      i_duplex_pol_strap = k[0];
      i_speed_pol_strap = k[1];
      full = k[0] ^ k[1];
      fast = k[0];
      tick(8);
      chk(o_full_duplex, 32'(full == k[0]));
      chk(o_speed_100, k[2] ? 32'(k[0] == k[1]) : 32'h1);
    end
    $display("mac done");
  endtask
  task automatic t_iso;
    i_mode = 2'h1;
    mm_wr(12'h1C0, 32'h1400);
    tick(1);
    chk({o_rmii_out_disable, o_rmii_pull_disable, o_rmii_in_power_down}, 32'h7);
    smi(1'h0, 5'h00, 16'h1400);
    i_mode = 2'h3;
    tick(2);
    chk({o_rmii_out_disable, o_rmii_in_power_down}, 32'h0);
    $display("isolate done");
  endtask
  task automatic t_reset;
    i_mode = 2'h0;
    mm_wr(12'h1C0, 32'h6D80);
    tick(1);
    // The reset write itself sets loopback, bit seven and manual 10 Mbps half duplex,
    // so only the reset can bring the defaults back.
    mm_wr(12'h1C0, 32'hC080);
    tick(1);
    chk(o_soft_reset_pulse, 32'h1);
    tick(1);
    chk({o_speed_100, o_full_duplex, o_loop_enable, o_soft_reset_pulse}, 32'hC);
    mm_rd(12'h1C0, 32'h1000);
    $display("soft reset done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence after a 20 cycle reset.
  initial begin
    tick(20);
    i_sys_rst = 1'h0;
    tick(1);
    t_fields;
    t_manual;
    t_mac;
    t_iso;
    t_reset;
    report_and_stop;
  end
  // The sequence needs about 130 cycles; reaching the 2000 cycle limit means a hang.
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
endmodule

// ---- tb/vphyc_far_model.sv ----
`timescale 1ns/10ps
// ****
// External PHY indication pins
// ****
module vphyc_far_model (
  // Clock and commanded link state
  input wire logic i_clk,
  input wire logic i_full,
  input wire logic i_fast,
  // Indication pins
  output logic o_duplex,
  output logic o_speed
);
  // Pins move off the edge, since the real PHY is not on this clock.
  always @(posedge i_clk) begin
    #3;
    o_duplex <= i_full;
    o_speed <= i_fast;
  end
endmodule

// ---- tb/vphyc_props.sv ----
`timescale 1ns/10ps
// ****
// Control word properties
// ****
module vphyc_props (
  // Clock, reset and stimulus
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_mm_addr,
  input wire logic i_mm_wr_en,
  input wire logic i_mm_rd_en,
  input wire logic [31:0] i_mm_wdata,
  input wire logic [1:0] i_mode,
  // Observed outputs
  input wire logic [31:0] o_mm_rdata,
  input wire logic o_mm_rd_valid,
  input wire logic o_speed_100,
  input wire logic o_full_duplex,
  input wire logic o_loop_enable,
  input wire logic o_rmii_out_disable,
  input wire logic o_rmii_pull_disable,
  input wire logic o_rmii_in_power_down,
  input wire logic o_soft_reset_pulse,
  input wire logic o_autoneg_restart_pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // A memory mapped write aimed at the control word.
  logic hit;
  assign hit = i_mm_wr_en && (i_mm_addr == 12'h1C0);
  rd_valid_a: assert property (i_mm_rd_en |=> o_mm_rd_valid)
    else $error("read not answered");
  rsvd_zero_a: assert property (o_mm_rd_valid |->
    o_mm_rdata[31:16] == 16'h0000 && o_mm_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  soft_rst_a: assert property (hit && i_mm_wdata[15] |->
    ##2 o_soft_reset_pulse ##1 !o_soft_reset_pulse)
    else $error("soft reset pulse wrong");
  an_restart_a: assert property (hit && i_mm_wdata[9] && !i_mm_wdata[15] |->
    ##2 o_autoneg_restart_pulse ##1 !o_autoneg_restart_pulse)
    else $error("restart pulse wrong");
  // Any memory mapped manual write with soft reset clear and negotiation off; the bench only sends 100 Mbps ones.
  manual_sel_a: assert property (hit && !i_mm_wdata[15] && !i_mm_wdata[12] |->
    ##2 {o_speed_100, o_full_duplex} == {$past(i_mm_wdata[13], 2), $past(i_mm_wdata[8], 2)})
    else $error("manual speed or duplex ignored");
  loop_follow_a: assert property (hit && !i_mm_wdata[15] |->
    ##2 o_loop_enable == $past(i_mm_wdata[14], 2))
    else $error("loop enable wrong");
  iso_mac_a: assert property (i_mode[1] && $past(i_mode[1]) |-> !o_rmii_out_disable)
    else $error("isolate acted in mac mode");
  iso_same_a: assert property (o_rmii_out_disable == o_rmii_pull_disable &&
    o_rmii_pull_disable == o_rmii_in_power_down)
    else $error("isolate outputs disagree");
  // Main scenarios reached.
  cover property (o_soft_reset_pulse);
  cover property (o_autoneg_restart_pulse);
  cover property (o_rmii_out_disable);
endmodule

bind vphyc_basic_control vphyc_props u_props (.i_clk, .i_sys_rst, .i_mm_addr, .i_mm_wr_en,
  .i_mm_rd_en, .i_mm_wdata, .i_mode, .o_mm_rdata, .o_mm_rd_valid, .o_speed_100,
  .o_full_duplex, .o_loop_enable, .o_rmii_out_disable, .o_rmii_pull_disable,
  .o_rmii_in_power_down, .o_soft_reset_pulse, .o_autoneg_restart_pulse);
